/* File: common/osfp_pkg.sv */
package osfp_pkg;
  localparam int CLK_MHZ = 200;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
  localparam int SHORT_DELAY_US = 160;
  localparam int OPEN_FILTER_US = 60;
  localparam int LATE_SHUT_US = 20;
  localparam int LATE_SHUT_CYC = LATE_SHUT_US * CLK_MHZ;
  localparam logic [7:0] STATUS_RESET = 8'hFF;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  typedef struct packed {
    logic [7:0] drain_trip;
    logic [7:0] over_temp;
    logic over_volt;
    logic logic_uv;
    logic load_uv;
  } osfp_fault_t;
endpackage

/* File: core/osfp_chan.sv */
`timescale 1ns/1ps
// One output channel: short-fault delay timer and shutdown latch.
module osfp_chan #(
  parameter int DELAY_TICKS = osfp_pkg::SHORT_DELAY_US
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Time base and control
  input wire logic i_tick,
  input wire logic i_apply,
  input wire logic i_cmd_on,
  input wire logic i_limit_mode,
  input wire logic i_short,
  // State
  output logic o_sc_off,
  output logic o_delay_done
);
  logic [15:0] delay_cnt;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      delay_cnt <= 16'h0000;
    end else if (i_apply) begin
      delay_cnt <= i_cmd_on ? 16'(DELAY_TICKS) : 16'h0000;
    end else if (i_tick && delay_cnt != 16'h0000) begin
      delay_cnt <= delay_cnt - 16'h0001;
    end
  end

  assign o_delay_done = (delay_cnt == 16'h0000);

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sc_off <= 1'b0;
    end else if (i_apply) begin
      o_sc_off <= 1'b0;
    end else if (!i_limit_mode && i_cmd_on && i_short && o_delay_done) begin
      o_sc_off <= 1'b1;
    end
  end

  a_late_short_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!i_limit_mode && i_cmd_on && i_short && o_delay_done && !i_apply) |=> o_sc_off)
    else $error("late short did not shut output");
  a_limit_never_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_limit_mode && !o_sc_off && !i_apply) |=> !o_sc_off)
    else $error("limit mode shut output");
  a_delay_holds_on: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_apply && i_cmd_on) |=> !o_sc_off && !o_delay_done)
    else $error("delay timer did not start");
endmodule // osfp_chan

/* File: core/osfp_core.sv */
`timescale 1ns/1ps
// Fault protection and status for eight low-side outputs.
module osfp_core #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Command link: chip select and the received word
  input wire logic i_cs_n,
  input wire logic [CHANNELS-1:0] i_cmd_word,
  // Mode and fault indications from the analog side
  input wire logic i_short_fault_mode_sel,
  input wire logic [CHANNELS-1:0] i_drain_fault_threshold,
  input wire logic [CHANNELS-1:0] i_over_temp,
  input wire logic [CHANNELS-1:0] i_open_load,
  input wire logic i_load_supply_rail_ov,
  input wire logic i_load_supply_rail_uv,
  input wire logic i_logic_uv,
  // Outputs
  output logic [CHANNELS-1:0] o_gate_on,
  output logic [CHANNELS-1:0] o_status_word,
  output logic o_current_limit_active
);
  // Sync stages; the first stage is never read by logic.
  logic [CHANNELS-1:0] trip_m, ot_m, ol_m;
  logic [CHANNELS-1:0] trip_s, ot_s, ol_s;
  logic [2:0] glob_m, glob_s;
  logic cs_m, cs_s, cs_d, mode_m, mode_s;
  logic apply;
  logic tick;
  logic [15:0] tick_cnt;
  logic [CHANNELS-1:0] cmd_on;
  logic [CHANNELS-1:0] sc_off;
  logic [CHANNELS-1:0] delay_done;
  logic [CHANNELS-1:0] chan_cmd;
  logic [CHANNELS-1:0] ot_latch;
  logic ov_latch;
  logic ov_report;
  logic [15:0] ol_cnt;
  logic [CHANNELS-1:0] next_gate;
  logic [CHANNELS-1:0] next_status;
  osfp_pkg::osfp_fault_t flt;

  // Per-output comparator, temperature and open-load flags.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trip_m <= '0;
      trip_s <= '0;
      ot_m <= '0;
      ot_s <= '0;
      ol_m <= '0;
      ol_s <= '0;
    end else begin
      trip_m <= i_drain_fault_threshold;
      trip_s <= trip_m;
      ot_m <= i_over_temp;
      ot_s <= ot_m;
      ol_m <= i_open_load;
      ol_s <= ol_m;
    end
  end

  // Supply monitors and the mode pin.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      glob_m <= 3'h0;
      glob_s <= 3'h0;
      mode_m <= 1'b0;
      mode_s <= 1'b0;
    end else begin
      glob_m <= {i_load_supply_rail_ov, i_load_supply_rail_uv, i_logic_uv};
      glob_s <= glob_m;
      mode_m <= i_short_fault_mode_sel;
      mode_s <= mode_m;
    end
  end

  // Chip select has a third flop so that its rising edge can be found.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      cs_m <= i_cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
    end
  end

  always_comb begin
    flt.drain_trip = trip_s;
    flt.over_temp = ot_s;
    flt.over_volt = glob_s[2];
    flt.load_uv = glob_s[1];
    flt.logic_uv = glob_s[0];
  end

  // The received word is applied on the chip-select rising edge.
  assign apply = cs_s && !cs_d;

  // One microsecond tick from a free-running divider.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt <= 16'h0000;
    end else if (tick_cnt == 16'(osfp_pkg::TICK_CYC - 1)) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = (tick_cnt == 16'(osfp_pkg::TICK_CYC - 1));

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cmd_on <= '0;
    end else if (flt.logic_uv) begin
      cmd_on <= '0;
    end else if (apply) begin
      cmd_on <= ~i_cmd_word;
    end
  end

  // The delay timer must start from the word being applied, not the one it replaces.
  assign chan_cmd = apply ? ~i_cmd_word : cmd_on;

  // A hot output stays off after it cools until a write commands it again.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ot_latch <= '0;
    end else begin
      ot_latch <= flt.over_temp | (apply ? '0 : ot_latch);
    end
  end

  // Over-voltage turns everything off until a word arrives after it clears.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ov_latch <= 1'b0;
    end else if (flt.over_volt) begin
      ov_latch <= 1'b1;
    end else if (apply) begin
      ov_latch <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ov_report <= 1'b0;
    end else if (flt.over_volt) begin
      ov_report <= 1'b1;
    end else if (apply) begin
      ov_report <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      osfp_chan #(
        .DELAY_TICKS(osfp_pkg::SHORT_DELAY_US)
      ) u_chan (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_tick(tick),
        .i_apply(apply),
        .i_cmd_on(chan_cmd[g]),
        .i_limit_mode(mode_s),
        .i_short(flt.drain_trip[g] && o_gate_on[g]),
        .o_sc_off(sc_off[g]),
        .o_delay_done(delay_done[g])
      );
    end
  endgenerate

  // Open-load filter: one shared timer restarted by every chip-select rising edge.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ol_cnt <= 16'h0000;
    end else if (apply) begin
      ol_cnt <= 16'(osfp_pkg::OPEN_FILTER_US);
    end else if (tick && ol_cnt != 16'h0000) begin
      ol_cnt <= ol_cnt - 16'h0001;
    end
  end

  always_comb begin
    next_gate = cmd_on & ~sc_off & ~flt.over_temp & ~ot_latch;
    if (ov_latch || flt.over_volt || flt.logic_uv) begin
      next_gate = '0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_gate_on <= '0;
    end else begin
      o_gate_on <= next_gate;
    end
  end

  // Status bit high means off or faulted; low means on, or off with open load.
  always_comb begin
    next_status = ~o_gate_on | (o_gate_on & flt.drain_trip);
    next_status = next_status & ~(~cmd_on & (ol_cnt == 16'h0000 ? ol_s : '0));
    if (ov_report) begin
      next_status = osfp_pkg::STATUS_RESET;
    end
  end

  // Status word is captured as chip select falls and held through the transfer, so it shows the prior word's result.
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_status_word <= osfp_pkg::STATUS_RESET;
    end else if (flt.logic_uv) begin
      o_status_word <= osfp_pkg::STATUS_RESET;
    end else if (!cs_s) begin
      o_status_word <= o_status_word;
    end else begin
      o_status_word <= next_status;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_current_limit_active <= 1'b0;
    end else begin
      o_current_limit_active <= mode_s && |(o_gate_on & flt.drain_trip);
    end
  end

  a_uv_all_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    flt.logic_uv |=> (o_gate_on == '0) && (o_status_word == osfp_pkg::STATUS_RESET))
    else $error("logic under-voltage left output on");
  a_uv_cmd_clear: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    flt.logic_uv |=> cmd_on == '0)
    else $error("logic under-voltage kept a command");
  a_ov_all_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    flt.over_volt |=> o_gate_on == '0)
    else $error("over-voltage left output on");
  a_ov_latched: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ($fell(flt.over_volt) && !apply) |-> next_gate == '0)
    else $error("over-voltage latch released early");
  a_ov_ones: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (ov_report && cs_s) |=> o_status_word == osfp_pkg::STATUS_RESET)
    else $error("status after over-voltage not all ones");
  a_ot_off: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (flt.over_temp != '0) |=> (o_gate_on & $past(flt.over_temp)) == '0)
    else $error("hot output stayed on");
  a_ot_latched: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (ot_latch != '0) |=> (o_gate_on & $past(ot_latch)) == '0)
    else $error("cooled output came back without a write");
  a_sc_latched: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (sc_off != '0) |=> (o_gate_on & $past(sc_off)) == '0)
    else $error("shut output came back without a write");
  a_cmd_apply: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (apply && !flt.logic_uv) |=> cmd_on == ~$past(i_cmd_word))
    else $error("command word not applied");
  a_filter_start: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    apply |=> ol_cnt == 16'(osfp_pkg::OPEN_FILTER_US))
    else $error("open-load filter did not restart");
  a_tick_period: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    tick |-> ##200 tick)
    else $error("time base tick period wrong");
  a_status_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!cs_s && !flt.logic_uv) |=> $stable(o_status_word))
    else $error("status changed during transfer");
endmodule // osfp_core

/* File: sim/osfp_core_tb_top.sv */
`timescale 1ns/1ps
module osfp_core_tb_top;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic cs_n;
  logic [7:0] cmd_word, gate, status, st, flt;
  logic [7:0] trip = 8'h00;
  logic [7:0] otemp = 8'h00;
  logic [7:0] open_load = 8'h00;
  logic mode = 1'b0;
  logic ov = 1'b0;
  logic luv = 1'b0;
  logic vuv = 1'b0;
  logic limit;
  int err_total = 0;
  int tests_run = 0;

  always #2.5 i_ref_clk = ~i_ref_clk;

  osfp_host_model osfp_host_model_inst (.i_ref_clk(i_ref_clk), .i_status_word(status),
    .o_cs_n(cs_n), .o_cmd_word(cmd_word), .o_fault_seen(flt));

  osfp_core osfp_core_inst (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
    .i_cmd_word(cmd_word), .i_short_fault_mode_sel(mode), .i_drain_fault_threshold(trip),
    .i_over_temp(otemp), .i_open_load(open_load), .i_load_supply_rail_ov(ov),
    .i_load_supply_rail_uv(vuv), .i_logic_uv(luv), .o_gate_on(gate),
    .o_status_word(status), .o_current_limit_active(limit));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask

  task automatic wr(input logic [7:0] w);
    osfp_host_model_inst.xfer(w, st);
  endtask

  task automatic t_late_short();
    wr(8'h5A);
    chk(gate, 8'hA5, "gates follow word");
    cyc(32200);
    open_load[1] = 1'b1;
    trip[0] = 1'b1;
    cyc(4000);
    chk(gate, 8'hA4, "late short off");
    trip[0] = 1'b0;
    cyc(8);
    chk(gate, 8'hA4, "stays off after removal");
    wr(8'h5A);
    chk(st, 8'h59, "status bits");
    chk(flt, 8'h03, "host compare");
    chk(gate, 8'hA5, "next write restores");
    open_load[1] = 1'b0;
    $display("test late_short done");
  endtask

  task automatic t_early_short();
    trip[0] = 1'b1;
    wr(8'hFE);
    cyc(20000);
    chk(gate, 8'h01, "on during delay");
    cyc(12300);
    chk(gate, 8'h00, "off after delay");
    trip[0] = 1'b0;
    $display("test early_short done");
  endtask

  task automatic t_limit();
    mode = 1'b1;
    wr(8'hFE);
    trip[0] = 1'b1;
    cyc(2000);
    chk(gate, 8'h01, "limit keeps on");
    chk({7'h00, limit}, 8'h01, "limit active");
    wr(8'hFE);
    chk(st, 8'hFF, "over-current reported");
    trip[0] = 1'b0;
    cyc(8);
    chk({7'h00, limit}, 8'h00, "limit released");
    chk(gate, 8'h01, "still on");
    mode = 1'b0;
    $display("test limit done");
  endtask

  task automatic t_faults();
    wr(8'h00);
    otemp[2] = 1'b1;
    cyc(100);
    chk(gate, 8'hFB, "thermal one output");
    otemp[2] = 1'b0;
    cyc(8);
    chk(gate, 8'hFB, "thermal latched after cooling");
    wr(8'h08);
    chk(gate, 8'hF7, "recovered by write");
    open_load[3] = 1'b1;
    cyc(12100);
    ov = 1'b1;
    cyc(8);
    chk(gate, 8'h00, "over-voltage off");
    ov = 1'b0;
    cyc(8);
    chk(gate, 8'h00, "latched off");
    wr(8'h00);
    chk(st, 8'hFF, "all ones after OV");
    open_load[3] = 1'b0;
    chk(gate, 8'hFF, "new word restores");
    vuv = 1'b1;
    cyc(50);
    chk(gate, 8'hFF, "load uv ignored");
    vuv = 1'b0;
    luv = 1'b1;
    cyc(8);
    chk(gate, 8'h00, "logic uv off");
    chk(status, 8'hFF, "logic uv status");
    luv = 1'b0;
    $display("test faults done");
  endtask

  task automatic print_verdict();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    cyc(12);
    i_resetn = 1'b1;
    cyc(6);
    chk(gate, 8'h00, "reset gates");
    chk(status, 8'hFF, "reset status");
    t_late_short();
    t_early_short();
    t_limit();
    t_faults();
    print_verdict();
  end

  // The tests need about 420 us; the limit leaves some room and keeps the run short.
  initial begin
    #470000;
    err_total++;
    print_verdict();
  end
endmodule // osfp_core_tb_top

/* File: sim/osfp_host_model.sv */
`timescale 1ns/1ps
// Host side of the command link: one command word per chip-select pulse.
module osfp_host_model (
  // Clock
  input wire logic i_ref_clk,
  // Link
  input wire logic [7:0] i_status_word,
  output logic o_cs_n,
  output logic [7:0] o_cmd_word,
  // Faults found by comparing status with the previous word
  output logic [7:0] o_fault_seen
);
  logic [7:0] last_cmd;

  initial begin
    o_cs_n = 1'b1;
    o_cmd_word = 8'hFF;
    o_fault_seen = 8'h00;
    last_cmd = 8'hFF;
  end

  // The frame spans eight 48 ns link periods; the word stays put after the frame
  // because the core samples it a few cycles after the chip-select edge.
  task automatic xfer(input logic [7:0] word, output logic [7:0] status);
    @(negedge i_ref_clk);
    o_cs_n = 1'b0;
    o_cmd_word = word;
    #384;
    @(negedge i_ref_clk);
    status = i_status_word;
    o_fault_seen = status ^ last_cmd;
    last_cmd = word;
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_ref_clk);
  endtask
endmodule // osfp_host_model
